// ---- ssw_pkg.sv ----
/*
 * Shared constants and carrier types for the supply supervisor with
 * watchdog. Assumes a single 200 MHz system clock.
 */
package ssw_pkg;

   localparam int unsigned CLK_HZ          = 200_000_000;
   // Prescaler gives a 1 kHz tick; all long times count in milliseconds
   localparam int unsigned TICK_HZ         = 1_000;
   localparam int unsigned PRESCALE_CYC    = CLK_HZ / TICK_HZ;
   localparam int unsigned RESET_STRETCH_MS = 200;
   localparam int unsigned WDOG_TIMEOUT_MS  = 1_600;
   localparam int unsigned RESET_STRETCH_TICKS =
      RESET_STRETCH_MS * TICK_HZ / 1_000;
   localparam int unsigned WDOG_TIMEOUT_TICKS =
      WDOG_TIMEOUT_MS * TICK_HZ / 1_000;
   localparam int unsigned TICK_W = 16;

   // Digital flags from the analog front end
   typedef struct packed {
      logic main_ok;       // Main supply above reset threshold
      logic backup_higher; // Backup supply above main supply
      logic pfail_above;   // Power-fail input above reference
      logic wdog_high;     // Watchdog input reads high
      logic wdog_float;    // Watchdog input at mid-supply level
   } ssw_flags_type;

   typedef struct packed {
      logic reset_n;
      logic reset_hi;
      logic power_fail_warn_n;
      logic switched_supply_sel_backup;
   } ssw_outs_type;

endpackage

// ---- ssw_sync.sv ----
/*
 * Two-stage synchroniser for a vector of level inputs.
 * Assumes inputs are asynchronous to clock; reset value is a parameter.
 */
`timescale 1ns/1ps
module ssw_sync #(
   parameter int unsigned                W         = 5,
   parameter logic [W-1:0]               RST_VAL   = '0
) (
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   input  wire logic [W-1:0]             d,
   output logic      [W-1:0]             q
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ---- ssw_supervisor.sv ----
/*
 * Supply supervisor: reset generation with stretch, three-level
 * watchdog, backup supply selection and power-fail forwarding.
 * Assumes analog comparators deliver asynchronous digital flags and that
 * rst_n is only the logic's own power-on reset, not a supervisor input.
 */
// Contract
// - Reset low while main supply below threshold
// - Hold reset 200 ms after supply recovers
// - Active-high reset is complement of reset_n
// - No watchdog edge for 1.6 s gives reset
// - Watchdog reset pulse lasts 200 ms
// - Each watchdog edge restarts timeout count
// - Constant watchdog input repeats pulse each timeout
// - Floating watchdog input disables watchdog
// - Select main supply when ok, else higher
// - Power-fail output follows comparator flag
// - Backup mode forces reset and power-fail outputs to fixed levels
// - Backup mode disables the watchdog
// - Backup supply absent never causes reset
`timescale 1ns/1ps
module ssw_supervisor
   import ssw_pkg::*;
#(
   parameter int unsigned PRESCALE = PRESCALE_CYC,
   parameter int unsigned STRETCH  = RESET_STRETCH_TICKS,
   parameter int unsigned TIMEOUT  = WDOG_TIMEOUT_TICKS
) (
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire ssw_pkg::ssw_flags_type flags_in,
   output ssw_pkg::ssw_outs_type     outs
);
   import ssw_pkg::*;

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_RUN,
      ST_WDOG_PULSE
   } ssw_state_type;

   ssw_flags_type flags_s;
   ssw_state_type state_r;
   ssw_state_type state_nxt;
   logic [31:0]   pre_r;
   logic [TICK_W-1:0] stretch_r;
   logic [TICK_W-1:0] stretch_nxt;
   logic [TICK_W-1:0] wd_r;
   logic [TICK_W-1:0] wd_nxt;
   logic          wd_level_r;
   logic          tick;
   logic          wd_edge;
   logic          wd_active;
   logic          wd_expire;
   logic          stretch_done;
   logic          backup_mode;
   logic          reset_n_nxt;

   // Flags start as "supply low" so reset asserts from power-on; the
   // watchdog line starts floating and low, matching wd_level_r, so no
   // false edge follows reset
   ssw_sync #(
      .W       (5),
      .RST_VAL (5'h01)
   ) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     (flags_in),
      .q     (flags_s)
   );

   // Prescaler: one-cycle tick every PRESCALE clocks
   assign tick = (pre_r == PRESCALE - 1);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= 32'h0;
      end else if (tick) begin
         pre_r <= 32'h0;
      end else begin
         pre_r <= pre_r + 32'h1;
      end
   end

   // Backup mode is main supply below threshold; backup presence is
   // never consulted for reset, so a missing battery cannot reset.
   assign backup_mode = !flags_s.main_ok;

   // Edge detection uses only synchronised levels
   assign wd_edge   = (flags_s.wdog_high != wd_level_r) &&
                      !flags_s.wdog_float;
   assign wd_active = !flags_s.wdog_float && !backup_mode
                      && (state_r == ST_RUN);
   assign wd_expire = wd_active && tick && !wd_edge &&
                      (wd_r == TICK_W'(TIMEOUT - 1));
   assign stretch_done = tick &&
                      (stretch_r == TICK_W'(STRETCH - 1));

   always_comb begin
      state_nxt   = state_r;
      stretch_nxt = stretch_r;
      wd_nxt      = wd_r;
      case (state_r)
         ST_HOLD: begin
            if (backup_mode) begin
               stretch_nxt = '0;
            end else if (stretch_done) begin
               state_nxt   = ST_RUN;
               stretch_nxt = '0;
               wd_nxt      = '0;
            end else if (tick) begin
               stretch_nxt = stretch_r + 1'b1;
            end
         end
         ST_RUN: begin
            if (backup_mode) begin
               state_nxt   = ST_HOLD;
               stretch_nxt = '0;
            end else if (!wd_active || wd_edge) begin
               wd_nxt      = '0;
            end else if (wd_expire) begin
               state_nxt   = ST_WDOG_PULSE;
               stretch_nxt = '0;
               wd_nxt      = '0;
            end else if (tick) begin
               wd_nxt      = wd_r + 1'b1;
            end
         end
         ST_WDOG_PULSE: begin
            if (backup_mode) begin
               state_nxt   = ST_HOLD;
               stretch_nxt = '0;
            end else if (stretch_done) begin
               state_nxt   = ST_RUN;
               stretch_nxt = '0;
               wd_nxt      = '0;
            end else if (tick) begin
               stretch_nxt = stretch_r + 1'b1;
            end
         end
         default: begin
            state_nxt = ST_HOLD;
         end
      endcase
   end

   assign reset_n_nxt = (state_nxt == ST_RUN);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= ST_HOLD;
         stretch_r  <= '0;
         wd_r       <= '0;
         wd_level_r <= 1'b0;
         outs       <= '{reset_n: 1'b0, reset_hi: 1'b1,
                         power_fail_warn_n: 1'b0,
                         switched_supply_sel_backup: 1'b0};
      end else begin
         state_r    <= state_nxt;
         stretch_r  <= stretch_nxt;
         wd_r       <= wd_nxt;
         wd_level_r <= flags_s.wdog_high;
         outs.reset_n  <= reset_n_nxt;
         outs.reset_hi <= !reset_n_nxt;
         // Comparator ignored in backup mode, output held low
         outs.power_fail_warn_n <= flags_s.pfail_above &&
                                   !backup_mode;
         outs.switched_supply_sel_backup <= backup_mode &&
                                   flags_s.backup_higher;
      end
   end

   // Helper: cycles spent in the watchdog pulse state
   logic [31:0] pulse_cyc_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cyc_r <= 32'h0;
      end else if (state_r == ST_WDOG_PULSE) begin
         pulse_cyc_r <= pulse_cyc_r + 32'h1;
      end else begin
         pulse_cyc_r <= 32'h0;
      end
   end

   // Helper: cycles of reset stretch with the supply already good
   logic [31:0] hold_cyc_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_cyc_r <= 32'h0;
      end else if (state_r == ST_HOLD && !backup_mode) begin
         hold_cyc_r <= hold_cyc_r + 32'h1;
      end else begin
         hold_cyc_r <= 32'h0;
      end
   end

   sequence s_run_entry;
      $rose(state_r == ST_RUN) && $past(state_r) == ST_HOLD;
   endsequence

   sequence s_supply_low;
      !flags_s.main_ok;
   endsequence

   sequence s_reset_held;
      !outs.reset_n [*2];
   endsequence

   a_reset_on_low: assert property (
      @(posedge clock) disable iff (!rst_n)
      s_supply_low |=> s_reset_held)
      else $error("reset not asserted with supply low");

   a_reset_complement: assert property (
      @(posedge clock) disable iff (!rst_n)
      outs.reset_hi == !outs.reset_n)
      else $error("active-high reset not complement");

   a_pfail_follow: assert property (
      @(posedge clock) disable iff (!rst_n)
      flags_s.main_ok && $past(flags_s.main_ok) |->
      outs.power_fail_warn_n == $past(flags_s.pfail_above))
      else $error("power-fail output wrong");

   a_backup_outs: assert property (
      @(posedge clock) disable iff (!rst_n)
      backup_mode |=> !outs.power_fail_warn_n && !outs.reset_n)
      else $error("backup mode outputs not forced");

   a_supply_select: assert property (
      @(posedge clock) disable iff (!rst_n)
      flags_s.main_ok |=> !outs.switched_supply_sel_backup)
      else $error("backup selected with main supply ok");

   a_wdog_float: assert property (
      @(posedge clock) disable iff (!rst_n)
      flags_s.wdog_float && state_r == ST_RUN |=>
      state_r != ST_WDOG_PULSE)
      else $error("watchdog fired while floating");

   a_wdog_backup: assert property (
      @(posedge clock) disable iff (!rst_n)
      backup_mode |=> state_r != ST_WDOG_PULSE)
      else $error("watchdog fired in backup mode");

   a_edge_restart: assert property (
      @(posedge clock) disable iff (!rst_n)
      state_r == ST_RUN && wd_edge && !backup_mode |=> wd_r == '0)
      else $error("watchdog count not restarted");

   a_pulse_length: assert property (
      @(posedge clock) disable iff (!rst_n)
      $fell(state_r == ST_WDOG_PULSE) && state_r == ST_RUN |->
      $past(pulse_cyc_r) >= 32'(PRESCALE * (STRETCH - 1)))
      else $error("watchdog pulse too short");

   a_expire_pulse: assert property (
      @(posedge clock) disable iff (!rst_n)
      wd_expire && !backup_mode |=> !outs.reset_n &&
      state_r == ST_WDOG_PULSE)
      else $error("timeout gave no reset pulse");

   // Free-running tick phase lets the stretch be up to one tick short
   a_stretch_length: assert property (
      @(posedge clock) disable iff (!rst_n)
      s_run_entry |-> $past(hold_cyc_r) >= 32'(PRESCALE * (STRETCH - 1)))
      else $error("reset released before stretch ended");

   a_low_to_hold: assert property (
      @(posedge clock) disable iff (!rst_n)
      backup_mode |=> state_r == ST_HOLD)
      else $error("supply low did not force hold");

   a_backup_reset_hi: assert property (
      @(posedge clock) disable iff (!rst_n)
      backup_mode |=> outs.reset_hi)
      else $error("active-high reset not asserted in backup");

   a_supply_backup: assert property (
      @(posedge clock) disable iff (!rst_n)
      !flags_s.main_ok && flags_s.backup_higher |=>
      outs.switched_supply_sel_backup)
      else $error("higher backup supply not selected");

   a_no_spurious_reset: assert property (
      @(posedge clock) disable iff (!rst_n)
      state_r == ST_RUN && !backup_mode && !wd_expire |=> outs.reset_n)
      else $error("reset asserted with supply good");

   a_float_clears: assert property (
      @(posedge clock) disable iff (!rst_n)
      flags_s.wdog_float && state_r == ST_RUN && !backup_mode |=>
      wd_r == '0)
      else $error("floating watchdog still counting");

   a_pulse_hold: assert property (
      @(posedge clock) disable iff (!rst_n)
      state_r == ST_WDOG_PULSE |-> !outs.reset_n)
      else $error("reset released during watchdog pulse");

   a_restart_after_pulse: assert property (
      @(posedge clock) disable iff (!rst_n)
      $fell(state_r == ST_WDOG_PULSE) && state_r == ST_RUN |-> wd_r == '0)
      else $error("timeout count not restarted after pulse");

   a_prescale_range: assert property (
      @(posedge clock) disable iff (!rst_n)
      pre_r < 32'(PRESCALE))
      else $error("prescaler beyond its period");

endmodule

// ---- ssw_cpu_model.sv ----
/*
 * Processor model that drives the three-level watchdog toggle line.
 * Assumes its controls change at the falling edge of clock.
 */
`timescale 1ns/1ps
module ssw_cpu_model (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       enable,
   input  wire logic [7:0] period,
   output logic            wdog_high,
   output logic            wdog_float
);
   // Static initialisers keep the line defined before the first edge
   logic       high_r  = 1'b0;
   logic       float_r = 1'b1;
   logic [7:0] cnt_r   = 8'h00;

   assign wdog_high  = high_r;
   assign wdog_float = float_r;

   always @(negedge clock) begin
      float_r <= !enable; // Buffer off leaves the line floating
      if (!enable) begin
         // A floating line drifts slowly, so a watchdog that ignored the
         // float level would time out between two crossings
         cnt_r <= cnt_r + 8'h01;
         if (cnt_r == 8'hff) begin
            high_r <= !high_r;
         end
      end else if (reset_n && period != 8'h00) begin
         cnt_r <= cnt_r + 8'h01;
         if (cnt_r + 8'h01 >= period) begin // Toggle inside timeout
            cnt_r <= 8'h00;
            high_r <= !high_r;
         end
      end
   end
endmodule

// ---- tb.sv ----
/*
 * Self-checking bench for the supply supervisor with watchdog.
 * Assumes short timing parameters so each time is a few ticks.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
      err_total++; \
   end \
end
module tb;
   import ssw_pkg::*;
   localparam int P = 4;
   localparam int S = 3;
   localparam int T = 5;
   typedef struct packed {
      logic [2:0] in;
      logic [3:0] exp;
   } ssw_row_type;
   logic          clock = 1'b0;
   logic          rst_n, en, mo, bh, pf, wh, wf;
   logic [7:0]    per;
   ssw_flags_type flags;
   ssw_outs_type  outs;
   ssw_row_type   rows [8];
   int            err_total, n_tests, n, i;

   assign flags = {mo, bh, pf, wh, wf};

   ssw_supervisor #(.PRESCALE(P), .STRETCH(S), .TIMEOUT(T)) i_ssw_supervisor (
      .clock    (clock),
      .rst_n    (rst_n),
      .flags_in (flags),
      .outs     (outs)
   );

   ssw_cpu_model i_ssw_cpu_model (
      .clock      (clock),
      .reset_n    (outs.reset_n),
      .enable     (en),
      .period     (per),
      .wdog_high  (wh),
      .wdog_float (wf)
   );

   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Counts edges until reset_n reaches v; gives up once the count passes maxc
   task automatic wait_rst(input logic v, input int maxc);
      n = 0;
      while (outs.reset_n !== v) begin
         @(posedge clock);
         #1;
         n++;
         `CHK("reset_hi", ~outs.reset_n, outs.reset_hi)
         if (n > maxc) begin
            err_total++;
            results();
         end
      end
      @(negedge clock);
   endtask

   initial begin
      forever #2.5 clock = ~clock;
   end

   initial begin
      rows = '{{3'h0, 4'h4}, {3'h2, 4'h5}, {3'h1, 4'h4}, {3'h3, 4'h5},
               {3'h4, 4'h8}, {3'h6, 4'h8}, {3'h5, 4'ha}, {3'h7, 4'ha}};
      rst_n = 1'b0;
      {mo, bh, pf, en} = 4'h0;
      per = 8'h00;
      err_total = 0;
      n_tests = 0;
      repeat (20) @(negedge clock);
      `CHK("reset outs", 4'h4, outs)
      rst_n = 1'b1;
      // Watchdog floats with a noisy line through all rows
      for (i = 0; i < 8; i++) begin
         {mo, bh, pf} = rows[i].in;
         repeat (40) @(negedge clock);
         `CHK("row outs", rows[i].exp, outs)
      end
      mo = 1'b0;
      wait_rst(1'b0, 4);
      `CHK("drop latency", 1'b1, n <= 4)
      repeat (10) @(negedge clock);
      mo = 1'b1;
      wait_rst(1'b1, (S + 1) * P + 6);
      `CHK("stretch", 1'b1, n >= 3 + (S - 1) * P)
      // Stalled processor: constant level on the line
      en <= 1'b1;
      wait_rst(1'b0, (T + 1) * P + 8);
      `CHK("wd timeout", 1'b1, n >= (T - 1) * P)
      wait_rst(1'b1, (S + 1) * P + 6);
      `CHK("wd pulse", 1'b1, n >= (S - 1) * P)
      wait_rst(1'b0, (T + 1) * P + 8);
      `CHK("wd repeat", 1'b1, n >= (T - 1) * P)
      wait_rst(1'b1, (S + 1) * P + 6);
      per <= 8'h08;
      repeat (200) begin
         @(negedge clock);
         `CHK("wd serviced", 1'b1, outs.reset_n)
      end
      results();
   end
endmodule
